//--- design/sixteen_bit_event_timer.v
// Contract
// - counter, two match values and capture are sixteen bits, counting up.
// - interval interrupt, count clock of 4 to 1024 system clocks.
// - two independent square-wave outputs, width 1 to 65536 counts.
// - pulse width measured in count periods, minimum three system clocks.
// - one-shot output goes active on software, inactive on match.
// - each output pin has its own one-shot control.
// - event mode counts one or both edges; source at most fclk/6.
// - also provides PWM output, cycle measurement and one-shot pulses.
// - five masked interrupt sources on irq: match a, match b, wrap, edge and width; the width bit is set by every valid edge, like edge.
// - run set from zero clears counter on first count clock.
// - match raises channel interrupt; match B may clear counter.
// - valid event edge copies counter into capture holding register.
// - counting past maximum wraps to zero and sets wrap flag.
//
// Purpose: 16-bit timer/event counter with AXI4-Lite registers
// Assumes: single clock mclk, asynchronous active-low reset
// Notes:   status bits are sticky and clear on read
`timescale 1ns/1ps
`include "event_timer_defines.vh"

module sixteen_bit_event_timer #(
   parameter CW = 16
) (
   // clock and reset
   input  wire          mclk,
   input  wire          arst_n,
   // axi4-lite write address
   input  wire [5:0]    s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   // axi4-lite write data
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   // axi4-lite read address
   input  wire [5:0]    s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   // axi4-lite read data
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   // pins
   input  wire          ext_event_input,
   output reg           wave_out_0,
   output reg           wave_out_1,
   // interrupts
   output wire          match_irq_a,
   output wire          match_irq_b,
   output reg           irq
);

   reg  [CW-1:0] up_counter_reg;
   reg  [CW-1:0] match_value_a_reg;
   reg  [CW-1:0] match_value_b_reg;
   reg  [CW-1:0] capture_holding_reg;
   reg  [4:0]    ctrl_reg;
   reg  [3:0]    prescale_reg;
   reg  [7:0]    outctl_reg;
   reg  [4:0]    status_reg;
   reg  [4:0]    mask_reg;
   reg  [9:0]    div_reg;
   reg           first_reg;
   reg  [1:0]    shot_reg;
   reg  [1:0]    toggle_reg;
   reg           aw_held_reg;
   reg           w_held_reg;
   reg  [5:0]    aw_addr_reg;
   reg  [31:0]   w_data_reg;
   reg  [3:0]    w_strb_reg;

   wire       run_bit = ctrl_reg[`CTRL_RUN];
   wire       ev_edge;
   wire       count_tick;
   wire       wrap_now;
   wire       hit_a;
   wire       hit_b;
   wire       wr_fire;
   wire       rd_fire;
   wire [3:0] wr_idx;
   wire [3:0] rd_idx;
   reg        tick_pre;
   reg [31:0] rd_word;

   edge_catcher u_edge (
      .mclk       (mclk),
      .arst_n     (arst_n),
      .pin_in     (ext_event_input),
      .edge_sel   (ctrl_reg[`CTRL_EDGE_HI:`CTRL_EDGE_LO]),
      .edge_pulse (ev_edge)
   );

   // write channel: address and data taken in either order
   assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
   assign wr_fire       = aw_held_reg & w_held_reg;
   assign wr_idx        = aw_addr_reg[5:2];
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid & s_axi_arready;
   assign rd_idx        = s_axi_araddr[5:2];

   always @* begin
      tick_pre = 1'b0;
      if (prescale_reg >= `PRS_MIN && prescale_reg <= `PRS_MAX)
         tick_pre = (div_reg & ((10'h002 << prescale_reg) - 10'h001)) == 10'h000;
   end
   // external edges drive the count in event mode
   assign count_tick = run_bit & ((prescale_reg == `PRS_EXT) ? ev_edge : tick_pre);

   // matches gated by run, before the first clear
   assign hit_a    = run_bit & ~first_reg & (up_counter_reg == match_value_a_reg);
   assign hit_b    = run_bit & ~first_reg & (up_counter_reg == match_value_b_reg);
   assign wrap_now = count_tick & ~first_reg & (up_counter_reg == `MAX16);

   // hold match irq as a one-cycle event per count period
   reg hit_a_q;
   reg hit_b_q;
   assign match_irq_a = hit_a & ~hit_a_q;
   assign match_irq_b = hit_b & ~hit_b_q;

   // counter, prescaler, capture
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         up_counter_reg      <= `ZERO16;
         capture_holding_reg <= `ZERO16;
         div_reg             <= 10'h000;
         first_reg           <= 1'b1;
         hit_a_q             <= 1'b0;
         hit_b_q             <= 1'b0;
      end else begin
         hit_a_q <= hit_a;
         hit_b_q <= hit_b;
         div_reg <= run_bit ? div_reg + 10'h001 : 10'h000;
         if (!run_bit) begin
            up_counter_reg <= `ZERO16;
            first_reg      <= 1'b1;
         end else if (count_tick) begin
            first_reg <= 1'b0;
            if (first_reg)
               up_counter_reg <= `ZERO16;
            else if (ctrl_reg[`CTRL_CLR_B] && up_counter_reg == match_value_b_reg)
               up_counter_reg <= `ZERO16;
            else
               up_counter_reg <= up_counter_reg + 16'h0001;
         end
         if (run_bit && ev_edge)
            capture_holding_reg <= up_counter_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : ch
         wire [3:0] oc   = outctl_reg[4*g+3:4*g];
         wire       m_ev = (g == 0) ? match_irq_a : match_irq_b;
         wire       trig = wr_fire && wr_idx == `OFF_ONESHOT && w_strb_reg[0] && w_data_reg[`OS_SET_LO+g];
         wire       kill = wr_fire && wr_idx == `OFF_ONESHOT && w_strb_reg[0] && w_data_reg[`OS_CLR_LO+g];
         always @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               toggle_reg[g] <= 1'b0;
               shot_reg[g]   <= 1'b0;
            end else begin
               // toggle on own match
               if (m_ev)
                  toggle_reg[g] <= ~toggle_reg[g];
               // pwm: set at match b, reset at match a
               // one-shot: software sets, own match ends it
               if (oc[`OC_MODE_HI:`OC_MODE_LO] == `OMODE_ONESHOT) begin
                  if (trig)
                     shot_reg[g] <= 1'b1;
                  else if (m_ev || kill)
                     shot_reg[g] <= 1'b0;
               end else if (oc[`OC_MODE_HI:`OC_MODE_LO] == `OMODE_PWM) begin
                  if (match_irq_b)
                     shot_reg[g] <= 1'b1;
                  else if (match_irq_a)
                     shot_reg[g] <= 1'b0;
               end else
                  shot_reg[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // pin drive: disabled pins sit at inactive level
   wire [1:0] act_lvl;
   assign act_lvl[0] = (outctl_reg[`OC_MODE_HI:`OC_MODE_LO] == `OMODE_TOGGLE) ? toggle_reg[0] : shot_reg[0];
   assign act_lvl[1] = (outctl_reg[4+`OC_MODE_HI:4+`OC_MODE_LO] == `OMODE_TOGGLE) ? toggle_reg[1] : shot_reg[1];
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wave_out_0 <= 1'b0;
         wave_out_1 <= 1'b0;
      end else begin
         wave_out_0 <= ~(outctl_reg[`OC_ACT_HIGH] ^ (outctl_reg[`OC_ENABLE] & act_lvl[0]));
         wave_out_1 <= ~(outctl_reg[4+`OC_ACT_HIGH] ^ (outctl_reg[4+`OC_ENABLE] & act_lvl[1]));
      end
   end

   // register writes, wrap flag; set wins over software clear
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg          <= 5'h00;
         prescale_reg      <= `PRS_RESET;
         match_value_a_reg <= `ZERO16;
         match_value_b_reg <= `ZERO16;
         outctl_reg        <= 8'h00;
         mask_reg          <= 5'h00;
      end else begin
         if (wr_fire) begin
            case (wr_idx)
               `OFF_CTRL:     if (w_strb_reg[0]) ctrl_reg <= w_data_reg[4:0];
               `OFF_PRESCALE: if (w_strb_reg[0]) prescale_reg <= w_data_reg[3:0];
               `OFF_MATCH_A:  if (&w_strb_reg[1:0]) match_value_a_reg <= w_data_reg[15:0];
               `OFF_MATCH_B:  if (&w_strb_reg[1:0]) match_value_b_reg <= w_data_reg[15:0];
               `OFF_OUTCTL:   if (w_strb_reg[0]) outctl_reg <= w_data_reg[7:0];
               `OFF_MASK:     if (w_strb_reg[0]) mask_reg <= w_data_reg[4:0];
               default:       ;
            endcase
         end
         if (wrap_now)
            ctrl_reg[`CTRL_WRAP] <= 1'b1;
      end
   end

   // sticky status, cleared by a read; new events still land
   wire [4:0] ev_vec = {ev_edge & run_bit, ev_edge & run_bit, wrap_now, match_irq_b, match_irq_a};
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         status_reg <= 5'h00;
         irq        <= 1'b0;
      end else begin
         if (rd_fire && rd_idx == `OFF_STATUS)
            status_reg <= ev_vec;
         else
            status_reg <= status_reg | ev_vec;
         irq <= |(status_reg & mask_reg);
      end
   end

   // read mux, unmapped words read zero with decerr
   always @* begin
      rd_word = 32'h0000_0000;
      case (rd_idx)
         `OFF_CTRL:     rd_word = {27'h0, ctrl_reg};
         `OFF_PRESCALE: rd_word = {28'h0, prescale_reg};
         `OFF_MATCH_A:  rd_word = {16'h0, match_value_a_reg};
         `OFF_MATCH_B:  rd_word = {16'h0, match_value_b_reg};
         `OFF_COUNT:    rd_word = {16'h0, up_counter_reg};
         `OFF_CAPTURE:  rd_word = {16'h0, capture_holding_reg};
         `OFF_STATUS:   rd_word = {27'h0, status_reg};
         `OFF_MASK:     rd_word = {27'h0, mask_reg};
         `OFF_OUTCTL:   rd_word = {24'h0, outctl_reg};
         default:       rd_word = 32'h0000_0000;
      endcase
   end

   // axi handshakes
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         aw_addr_reg  <= 6'h00;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `AXI_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= `AXI_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx <= `OFF_ONESHOT) ? `AXI_OKAY : `AXI_DECERR;
         end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= (rd_idx <= `OFF_ONESHOT) ? `AXI_OKAY : `AXI_DECERR;
         end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule

//--- inc/event_timer_defines.vh
// Purpose: constants for the sixteen bit event timer
// Assumes: AXI4-Lite register map, 32-bit words
// Notes:   offsets are word indices; byte address is four times the index
`ifndef EVENT_TIMER_DEFINES_VH
`define EVENT_TIMER_DEFINES_VH

// register word offsets
`define OFF_CTRL       4'h0
`define OFF_PRESCALE   4'h1
`define OFF_MATCH_A    4'h2
`define OFF_MATCH_B    4'h3
`define OFF_COUNT      4'h4
`define OFF_CAPTURE    4'h5
`define OFF_STATUS     4'h6
`define OFF_MASK       4'h7
`define OFF_OUTCTL     4'h8
`define OFF_ONESHOT    4'h9

// control register fields
`define CTRL_RUN       0
`define CTRL_WRAP      1
`define CTRL_CLR_B     2
`define CTRL_EDGE_LO   3
`define CTRL_EDGE_HI   4

// output control fields, per channel n at bit 4*n
`define OC_ENABLE      0
`define OC_ACT_HIGH    1
`define OC_MODE_LO     2
`define OC_MODE_HI     3

// output modes
`define OMODE_TOGGLE   2'h0
`define OMODE_PWM      2'h1
`define OMODE_ONESHOT  2'h2

// one-shot register: set bit n, clear bit n+2
`define OS_SET_LO      0
`define OS_CLR_LO      2

// edge select codes
`define EDGE_RISE      2'h0
`define EDGE_FALL      2'h1
`define EDGE_BOTH      2'h2

// prescaler codes
`define PRS_MIN        4'h1
`define PRS_MAX        4'h9
`define PRS_EXT        4'hf
`define PRS_RESET      4'h1

// status bits
`define ST_MATCH_A     0
`define ST_MATCH_B     1
`define ST_WRAP        2
`define ST_EDGE        3
`define ST_WIDTH       4

// reset values and constants
`define ZERO16         16'h0000
`define MAX16          16'hffff
`define AXI_OKAY       2'h0
`define AXI_DECERR     2'h3

`endif

//--- design/edge_catcher.v
// Purpose: synchronise the event pin and flag its valid edges
// Assumes: pin held at least three mclk periods per level
// Notes:   two-flop synchroniser, then edge select
`timescale 1ns/1ps
`include "event_timer_defines.vh"

module edge_catcher (
   // clock and reset
   input  wire       mclk,
   input  wire       arst_n,
   // pin and selection
   input  wire       pin_in,
   input  wire [1:0] edge_sel,
   // result
   output wire       edge_pulse
);

   reg sync1_reg;
   reg sync2_reg;
   reg last_reg;

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         last_reg  <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         last_reg  <= sync2_reg;
      end
   end

   // edge decode on synchronised copy only
   wire rise = sync2_reg & ~last_reg;
   wire fall = ~sync2_reg & last_reg;
   assign edge_pulse = (edge_sel == `EDGE_RISE) ? rise :
                       (edge_sel == `EDGE_FALL) ? fall :
                       (edge_sel == `EDGE_BOTH) ? (rise | fall) : 1'b0;

endmodule

//--- dv/timer_props_properties.sv
// Purpose: port checks for the event timer
// Assumes: one clock domain, reset low keeps the bus quiet
// Notes:   bound to every timer instance below
`timescale 1ns/1ps
module timer_props #(
   parameter CW = 16
) (
   // clock and reset
   input wire        mclk,
   input wire        arst_n,
   // register bus
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [5:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // match pulses
   input wire        match_irq_a,
   input wire        match_irq_b
);
   // one clock, so one default for all checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   // match pulses last a single cycle
   property p_irq_a_once; match_irq_a |=> !match_irq_a; endproperty
   a_irq_a_once: assert property (p_irq_a_once) else $error("match a pulse too long");
   property p_irq_b_once; match_irq_b |=> !match_irq_b; endproperty
   a_irq_b_once: assert property (p_irq_b_once) else $error("match b pulse too long");

   // values never exceed the counter width
   property p_rdata_width; s_axi_rvalid |-> (s_axi_rdata >> CW) == 32'h0; endproperty
   a_rdata_width: assert property (p_rdata_width) else $error("read data above counter width");

   // read answer one cycle after the address, held until taken
   property p_read_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_read_lat: assert property (p_read_lat) else $error("read answer late");
   property p_read_end; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_read_end: assert property (p_read_end) else $error("read answer not released");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("address taken during answer");

   // unmapped reads give decode error and zero
   property p_decerr;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] > 4'h9 |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0;
   endproperty
   a_decerr: assert property (p_decerr) else $error("unmapped read not refused");

   // write answer two cycles after both items arrive together
   property p_wr_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer timing wrong");
   property p_b_end; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_end: assert property (p_b_end) else $error("write answer not released");
endmodule

bind sixteen_bit_event_timer timer_props #(.CW(CW)) u_props (.mclk, .arst_n, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .match_irq_a, .match_irq_b);

//--- dv/event_pulse_source.sv
// Purpose: external pulse source on the event input
// Assumes: level times counted in mclk cycles
// Notes:   idles low; a go pulse starts one burst
`timescale 1ns/1ps
module event_pulse_source (
   // clock
   input wire       mclk,
   // burst request
   input wire       go,
   input wire [7:0] half,
   input wire [7:0] pulses,
   // pin and status
   output reg       ext_event_input,
   output reg       busy
);
   // burst engine; short requests are stretched, never shortened below the floor
   initial begin
      ext_event_input = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge mclk);
         if (go) begin
            busy <= 1'b1;
            repeat (pulses) begin
               repeat (half < 8'd3 ? 8'd3 : half) @(posedge mclk);
               ext_event_input <= 1'b1;
               repeat (half < 8'd3 ? 8'd3 : half) @(posedge mclk);
               ext_event_input <= 1'b0;
            end
            repeat (8) @(posedge mclk);
            busy <= 1'b0;
         end
      end
   end
endmodule

//--- dv/tb_sixteen_bit_event_timer.sv
// Purpose: self-checking bench for the event timer
// Assumes: 200 MHz mclk, bus answers as handed over
// Notes:   match b clearing keeps every period short
`timescale 1ns/1ps
`include "event_timer_defines.vh"
module tb_sixteen_bit_event_timer;
   // bench drive
   reg         mclk = 1'b0;
   reg         arst_n = 1'b0;
   reg  [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'hf;
   reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0;
   reg  [7:0]  pulses = 8'h00;
   // design and model outputs
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        ext_event_input, wave_out_0, wave_out_1, match_irq_a, match_irq_b, irq, busy;
   integer     failures = 0, cmp_count = 0, p, e;
   reg  [31:0] d;
   reg  [1:0]  last_resp;
   reg         v;

   sixteen_bit_event_timer dut_u (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .ext_event_input, .wave_out_0, .wave_out_1, .match_irq_a, .match_irq_b, .irq);
   event_pulse_source src_u (.mclk, .go, .half(8'd3), .pulses, .ext_event_input, .busy);

   // 5 ns clock
   initial forever #2.5 mclk = ~mclk;

   function [5:0] ba(input [3:0] i); ba = {i, 2'b00}; endfunction

   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // bus write: both items offered together, each dropped when taken
   task wr(input [5:0] a, input [31:0] wd);
      reg ap, wp, bd;
      integer n;
      begin
         ap = 1'b1; wp = 1'b1; bd = 1'b0; n = 0;
         @(posedge mclk);
         s_axi_awaddr <= a; s_axi_wdata <= wd;
         s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
         while (!bd && n < 64) begin
            @(posedge mclk);
            if (ap && s_axi_awready) begin ap = 1'b0; s_axi_awvalid <= 1'b0; end
            if (wp && s_axi_wready) begin wp = 1'b0; s_axi_wvalid <= 1'b0; end
            if (s_axi_bvalid) begin bd = 1'b1; s_axi_bready <= 1'b0; last_resp = s_axi_bresp; end
            n = n + 1;
         end
         if (!bd) failures = failures + 1;
      end
   endtask

   // bus read: rready held until the answer is sampled
   task rd(input [5:0] a, output [31:0] rdv);
      reg ap, rdn;
      integer n;
      begin
         ap = 1'b1; rdn = 1'b0; n = 0; rdv = 32'h0;
         @(posedge mclk);
         s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
         while (!rdn && n < 64) begin
            @(posedge mclk);
            if (!ap && s_axi_rvalid) begin rdn = 1'b1; s_axi_rready <= 1'b0; rdv = s_axi_rdata; end
            if (ap && s_axi_arready) begin ap = 1'b0; s_axi_arvalid <= 1'b0; end
            last_resp = s_axi_rresp;
            n = n + 1;
         end
         if (!rdn) failures = failures + 1;
      end
   endtask

   // cycles until the next match pulse of one channel
   task wait_irq(input sel, output integer cyc);
      begin
         cyc = 0;
         do begin @(posedge mclk); cyc = cyc + 1; end while (!(sel ? match_irq_b : match_irq_a) && cyc < 5000);
         if (cyc >= 5000) failures = failures + 1;
      end
   endtask

   task burst(input [7:0] n);
      integer k;
      begin
         k = 0;
         @(posedge mclk); go <= 1'b1; pulses <= n;
         @(posedge mclk); go <= 1'b0;
         do begin @(posedge mclk); k = k + 1; end while (busy && k < 5000);
         if (k >= 5000) failures = failures + 1;
      end
   endtask

   task t_reset;
      integer i;
      begin
         for (i = 0; i < 10; i = i + 1) if (i != `OFF_CAPTURE) begin
            rd(ba(i), d);
            chk(d, i == `OFF_PRESCALE ? {28'h0, `PRS_RESET} : 32'h0);
         end
         rd(6'h28, d); chk({30'h0, last_resp}, {30'h0, `AXI_DECERR});
         wr(ba(`OFF_COUNT), 32'h1234);
         chk({30'h0, last_resp}, {30'h0, `AXI_OKAY});
         rd(ba(`OFF_COUNT), d); chk(d, 32'h0);
         wr(6'h28, 32'h1);
         chk({30'h0, last_resp}, {30'h0, `AXI_DECERR});
         chk({30'h0, wave_out_1, wave_out_0}, 32'h3);
      end
   endtask

   // prescale codes 1 to 9: period of two count clocks with match b clearing
   task t_prescale;
      integer c;
      begin
         wr(ba(`OFF_MATCH_B), 32'h1); wr(ba(`OFF_CTRL), 32'h5);
         for (c = `PRS_MIN; c <= `PRS_MAX; c = c + 1) begin
            wr(ba(`OFF_PRESCALE), c); wait_irq(1'b1, p); wait_irq(1'b1, p);
            chk(p, 2 << (c + 1));
         end
      end
   endtask

   task t_irq;
      begin
         wr(ba(`OFF_MASK), 32'h0); wr(ba(`OFF_MATCH_A), 32'h3); wr(ba(`OFF_MATCH_B), 32'h7);
         wr(ba(`OFF_PRESCALE), 32'h1); wr(ba(`OFF_CTRL), 32'h5);
         wait_irq(1'b0, p); wait_irq(1'b0, p); chk(p, 32);
         chk({31'h0, irq}, 32'h0);
         wr(ba(`OFF_MASK), 32'h1); repeat (2) @(posedge mclk); chk({31'h0, irq}, 32'h1);
         wr(ba(`OFF_CTRL), 32'h0); rd(ba(`OFF_COUNT), d); chk(d, 32'h0);
         rd(ba(`OFF_STATUS), d); chk(d, 32'h3);
         rd(ba(`OFF_STATUS), d); chk(d, 32'h0);
         repeat (2) @(posedge mclk); chk({31'h0, irq}, 32'h0);
      end
   endtask

   // external counting for each edge selection, five pulses
   task t_events;
      begin
         wr(ba(`OFF_PRESCALE), {28'h0, `PRS_EXT});
         for (e = 0; e < 3; e = e + 1) begin
            wr(ba(`OFF_CTRL), (e << `CTRL_EDGE_LO) | 1); burst(8'd5);
            rd(ba(`OFF_COUNT), d); chk(d, e == `EDGE_BOTH ? 9 : 4);
            rd(ba(`OFF_CAPTURE), d); chk(d, e == `EDGE_BOTH ? 8 : 3);
            // setting run again while running must not clear the count
            wr(ba(`OFF_CTRL), (e << `CTRL_EDGE_LO) | 1);
            rd(ba(`OFF_COUNT), d);
            chk(d, e == `EDGE_BOTH ? 9 : 4);
            wr(ba(`OFF_CTRL), 32'h0);
         end
      end
   endtask

   task t_waves;
      begin
         wr(ba(`OFF_MATCH_A), 32'h4); wr(ba(`OFF_MATCH_B), 32'h9); wr(ba(`OFF_OUTCTL), 32'hbb);
         wr(ba(`OFF_PRESCALE), 32'h1); wr(ba(`OFF_CTRL), 32'h5);
         wait_irq(1'b1, p); wr(ba(`OFF_ONESHOT), 32'h2); @(posedge mclk);
         chk({30'h0, wave_out_1, wave_out_0}, 32'h2);
         wait_irq(1'b1, p); repeat (2) @(posedge mclk); chk({30'h0, wave_out_1, wave_out_0}, 32'h0);
         wait_irq(1'b0, p); wr(ba(`OFF_ONESHOT), 32'h1); @(posedge mclk);
         chk({30'h0, wave_out_1, wave_out_0}, 32'h1);
         wait_irq(1'b0, p); repeat (2) @(posedge mclk); chk({30'h0, wave_out_1, wave_out_0}, 32'h0);
         wr(ba(`OFF_OUTCTL), 32'h03); wait_irq(1'b0, p); repeat (2) @(posedge mclk); v = wave_out_0;
         wait_irq(1'b0, p); repeat (2) @(posedge mclk); chk({31'h0, wave_out_0}, {31'h0, ~v});
         // pwm on channel 0: active from match b until match a
         wr(ba(`OFF_OUTCTL), 32'h07);
         wait_irq(1'b1, p);
         repeat (2) @(posedge mclk);
         chk({31'h0, wave_out_0}, 32'h1);
         wait_irq(1'b0, p);
         repeat (2) @(posedge mclk);
         chk({31'h0, wave_out_0}, 32'h0);
         // software cancel ends a one-shot before its match
         wr(ba(`OFF_OUTCTL), 32'hbb);
         wait_irq(1'b1, p);
         wr(ba(`OFF_ONESHOT), 32'h2);
         @(posedge mclk);
         chk({30'h0, wave_out_1, wave_out_0}, 32'h2);
         wr(ba(`OFF_ONESHOT), 32'h8);
         @(posedge mclk);
         chk({30'h0, wave_out_1, wave_out_0}, 32'h0);
      end
   endtask

   task final_report;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, failures);
         if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   // watchdog well above the under 10k cycles the tests need
   initial begin
      repeat (60000) @(posedge mclk);
      failures = failures + 1;
      final_report;
   end

   // reset for four cycles, then the scenarios
   initial begin
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      t_reset;
      t_prescale;
      t_irq;
      t_events;
      t_waves;
      final_report;
   end
endmodule
